// >>> logic/cnt_irq_pkg.sv
// Purpose: Shared constants for the counter channel interrupt logic.
// Assumes: 32-bit AXI4-Lite register access, 100 MHz core clock.
// Notes:   Offsets are byte addresses of aligned words.
package cnt_irq_pkg;
    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int          NUM_CH        = 5;
    localparam int          GLITCH_CYCLES = 3;
    localparam logic [1:0]  GLITCH_MAX    = 2'h2;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0]  OFS_ENABLE    = 8'h00;
    localparam logic [7:0]  OFS_PENDING   = 8'h04;
    localparam logic [7:0]  OFS_CONTROL   = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h10;
    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int          CTL_MASTER_EN = 0;
    localparam int          STAT_GRANT    = 0;
    localparam int          STAT_REQ      = 1;
    localparam logic [4:0]  ENABLE_RST    = 5'h00;
    localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// >>> logic/glitch_filter.sv
// Purpose: Two-flop synchroniser and run-length glitch filter for one pulse line.
// Assumes: Input is asynchronous to the core clock.
// Notes:   Output is a one-cycle pulse on the rising edge of the filtered level.
`timescale 1ns/100ps
module glitch_filter (
    // Clock and reset
    input  wire logic I_CORE_CLK,
    input  wire logic I_RST,
    // Raw and filtered signal
    input  wire logic i_raw,
    output logic      o_rise
);
    logic       sync1_r;
    logic       sync2_r;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       lvl_r;
    logic       lvl_nxt;

    // The level must hold for several cycles before it counts, so short spikes vanish.
    always_comb begin
        cnt_nxt = cnt_r;
        lvl_nxt = lvl_r;
        if (sync2_r == lvl_r) begin
            cnt_nxt = 2'h0;
        end else if (cnt_r == cnt_irq_pkg::GLITCH_MAX) begin
            lvl_nxt = sync2_r;
            cnt_nxt = 2'h0;
        end else begin
            cnt_nxt = cnt_r + 2'h1;
        end
    end

    // Registers; the first sync stage feeds only the second.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            cnt_r   <= 2'h0;
            lvl_r   <= 1'b0;
        end else begin
            sync1_r <= i_raw;
            sync2_r <= sync1_r;
            cnt_r   <= cnt_nxt;
            lvl_r   <= lvl_nxt;
        end
    end

    // Pulse on the accepted rising edge.
    assign o_rise = lvl_nxt & ~lvl_r;
endmodule

// >>> logic/counter_channel_irq_logic.sv
// Purpose: Interrupt request logic for a five-channel counter module.
// Assumes: Bus grant arrives as a level from the bus processor, synchronised here.
// Notes:   Registers are reached over AXI4-Lite.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module counter_channel_irq_logic (
    // Clock and reset
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RST,
    // AXI4-Lite write channels
    input  wire logic [7:0]  I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    // AXI4-Lite read channels
    input  wire logic [7:0]  I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    // Counter overflow pulses and user inputs
    input  wire logic [4:0]  I_CNT_OVF,
    input  wire logic [4:0]  I_SRC_ISO,
    input  wire logic [4:0]  I_SRC_TTL,
    input  wire logic [4:0]  I_GATE_ISO,
    input  wire logic [4:0]  I_GATE_TTL,
    output logic [4:0]       O_CNT_SRC,
    output logic [4:0]       O_CNT_GATE,
    // System bus interrupt sequence
    input  wire logic        I_IRQ_GRANT,
    input  wire logic [15:0] I_VECTOR_SW,
    output logic             O_BUS_IRQ,
    output logic [15:0]      O_VEC_DATA,
    output logic             O_VEC_OE,
    // Local interrupt
    output logic             O_IRQ
);
    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ACK  = 2'b01,
        SEQ_DONE = 2'b10
    } seq_t;

    seq_t        seq_r, seq_nxt;
    logic [4:0]  enable_r, enable_nxt;
    logic [4:0]  flag_r, flag_nxt;
    logic        master_r, master_nxt;
    logic [1:0]  stat_r, stat_nxt;
    logic [1:0]  mask_r, mask_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic [15:0] vec_r, vec_nxt;
    logic        vec_oe_r, vec_oe_nxt;
    logic        gnt_s1_r, gnt_s2_r;
    logic [4:0]  ovf_rise;
    logic        wr_go;
    logic        rd_go;
    logic        grant_evt;
    logic        req_evt;

    // ************************************************************
    // Glitch filters, one per channel
    // ************************************************************
    // Spikes during counter programming must not raise requests.
    genvar g;
    generate
        for (g = 0; g < cnt_irq_pkg::NUM_CH; g++) begin : g_filt
            glitch_filter u_filt (
                .I_CORE_CLK (I_CORE_CLK),
                .I_RST      (I_RST),
                .i_raw      (I_CNT_OVF[g]),
                .o_rise     (ovf_rise[g])
            );
        end
    endgenerate

    // Counter inputs are combined from the isolated and plain user lines.
    assign O_CNT_SRC  = ~(I_SRC_ISO & I_SRC_TTL);
    assign O_CNT_GATE = ~(I_GATE_ISO & I_GATE_TTL);

    // ************************************************************
    // Bus handshake
    // ************************************************************
    // Address and data are taken together so the slave needs no holding latch.
    assign wr_go     = I_AWVALID & I_WVALID & ~bvalid_r;
    assign rd_go     = I_ARVALID & ~rvalid_r;
    assign O_AWREADY = wr_go;
    assign O_WREADY  = wr_go;
    assign O_ARREADY = rd_go;
    assign O_BVALID  = bvalid_r;
    assign O_BRESP   = bresp_r;
    assign O_RVALID  = rvalid_r;
    assign O_RDATA   = rdata_r;
    assign O_RRESP   = rresp_r;
    assign grant_evt = (seq_r == SEQ_ACK) & gnt_s2_r;
    assign req_evt   = |ovf_rise;

    // Next-state logic for registers, flags and the grant sequence.
    always_comb begin
        seq_nxt    = seq_r;
        enable_nxt = enable_r;
        flag_nxt   = flag_r;
        master_nxt = master_r;
        stat_nxt   = stat_r;
        mask_nxt   = mask_r;
        bvalid_nxt = bvalid_r & ~I_BREADY;
        bresp_nxt  = bresp_r;
        rvalid_nxt = rvalid_r & ~I_RREADY;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        vec_nxt    = vec_r;
        vec_oe_nxt = 1'b0;
        if (wr_go) begin
            bvalid_nxt = 1'b1;
            bresp_nxt  = cnt_irq_pkg::RESP_OKAY;
            if (I_AWADDR == cnt_irq_pkg::OFS_ENABLE) begin
                if (I_WSTRB[0]) enable_nxt = I_WDATA[4:0];
            end else if (I_AWADDR == cnt_irq_pkg::OFS_PENDING) begin
                if (I_WSTRB[0]) flag_nxt = flag_r & ~I_WDATA[4:0];
            end else if (I_AWADDR == cnt_irq_pkg::OFS_CONTROL) begin
                if (I_WSTRB[0]) master_nxt = I_WDATA[cnt_irq_pkg::CTL_MASTER_EN];
            end else if (I_AWADDR == cnt_irq_pkg::OFS_IRQ_STAT) begin
                if (I_WSTRB[0]) stat_nxt = stat_r & ~I_WDATA[1:0];
            end else if (I_AWADDR == cnt_irq_pkg::OFS_IRQ_MASK) begin
                if (I_WSTRB[0]) mask_nxt = I_WDATA[1:0];
            end else begin
                bresp_nxt = cnt_irq_pkg::RESP_SLVERR;
            end
        end
        // New pulses win over a clear in the same cycle.
        flag_nxt = flag_nxt | (ovf_rise & enable_r);
        // Grant sequence: wait for grant, present vector, release.
        case (seq_r)
            SEQ_IDLE: begin
                if (O_BUS_IRQ) seq_nxt = SEQ_ACK;
            end
            SEQ_ACK: begin
                if (gnt_s2_r) begin
                    master_nxt = 1'b0;
                    vec_nxt    = I_VECTOR_SW;
                    vec_oe_nxt = 1'b1;
                    seq_nxt    = SEQ_DONE;
                end else if (!O_BUS_IRQ) begin
                    seq_nxt = SEQ_IDLE;
                end
            end
            SEQ_DONE: begin
                vec_oe_nxt = gnt_s2_r;
                if (!gnt_s2_r) seq_nxt = SEQ_IDLE;
            end
            default: seq_nxt = SEQ_IDLE;
        endcase
        stat_nxt[cnt_irq_pkg::STAT_GRANT] = stat_nxt[cnt_irq_pkg::STAT_GRANT] | grant_evt;
        stat_nxt[cnt_irq_pkg::STAT_REQ]   = stat_nxt[cnt_irq_pkg::STAT_REQ] | req_evt;
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = cnt_irq_pkg::RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            if (I_ARADDR == cnt_irq_pkg::OFS_ENABLE) begin
                rdata_nxt[4:0] = enable_r;
            end else if (I_ARADDR == cnt_irq_pkg::OFS_PENDING) begin
                rdata_nxt[4:0] = flag_r;
            end else if (I_ARADDR == cnt_irq_pkg::OFS_CONTROL) begin
                rdata_nxt[cnt_irq_pkg::CTL_MASTER_EN] = master_r;
            end else if (I_ARADDR == cnt_irq_pkg::OFS_IRQ_STAT) begin
                rdata_nxt[1:0] = stat_r;
            end else if (I_ARADDR == cnt_irq_pkg::OFS_IRQ_MASK) begin
                rdata_nxt[1:0] = mask_r;
            end else begin
                rresp_nxt = cnt_irq_pkg::RESP_SLVERR;
            end
        end
    end

    // Register all state.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            seq_r    <= SEQ_IDLE;
            enable_r <= cnt_irq_pkg::ENABLE_RST;
            flag_r   <= 5'h00;
            master_r <= 1'b0;
            stat_r   <= 2'h0;
            mask_r   <= cnt_irq_pkg::IRQ_MASK_RST;
            bvalid_r <= 1'b0;
            bresp_r  <= 2'h0;
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= 2'h0;
            vec_r    <= 16'h0000;
            vec_oe_r <= 1'b0;
            gnt_s1_r <= 1'b0;
            gnt_s2_r <= 1'b0;
        end else begin
            seq_r    <= seq_nxt;
            enable_r <= enable_nxt;
            flag_r   <= flag_nxt;
            master_r <= master_nxt;
            stat_r   <= stat_nxt;
            mask_r   <= mask_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r  <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
            vec_r    <= vec_nxt;
            vec_oe_r <= vec_oe_nxt;
            gnt_s1_r <= I_IRQ_GRANT;
            gnt_s2_r <= gnt_s1_r;
        end
    end

    // Request is combinational so a pending flag shows as soon as master enable sets.
    assign O_BUS_IRQ  = (|flag_r) & master_r & (seq_r != SEQ_DONE);
    assign O_VEC_DATA = vec_r;
    assign O_VEC_OE   = vec_oe_r;
    assign O_IRQ      = |(stat_r & mask_r);

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_flag_needs_enable;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        $rose(flag_r[0]) |-> $past(enable_r[0]) && $past(ovf_rise[0]);
    endproperty
    a_flag_needs_enable: assert property (p_flag_needs_enable) else $error("Flag set without enable.");
    property p_flag_sets;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        (ovf_rise[1] && enable_r[1]) |=> flag_r[1];
    endproperty
    a_flag_sets: assert property (p_flag_sets) else $error("Enabled pulse lost.");
    property p_bus_req;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        ((|flag_r) && master_r && seq_r != SEQ_DONE) |-> O_BUS_IRQ;
    endproperty
    a_bus_req: assert property (p_bus_req) else $error("Bus request missing.");
    property p_no_req;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        !master_r |-> !O_BUS_IRQ;
    endproperty
    a_no_req: assert property (p_no_req) else $error("Request without master enable.");
    property p_grant_clears;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        (seq_r == SEQ_ACK && gnt_s2_r) |=> !master_r && O_VEC_OE && O_VEC_DATA == $past(I_VECTOR_SW);
    endproperty
    a_grant_clears: assert property (p_grant_clears) else $error("Grant did not clear enable.");
    property p_master_set_req;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        ($rose(master_r) && (|flag_r) && seq_r != SEQ_DONE) |-> O_BUS_IRQ;
    endproperty
    a_master_set_req: assert property (p_master_set_req) else $error("Pending flag not requested.");
    property p_flag_holds;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        $fell(flag_r[2]) |-> $past(wr_go) && $past(I_AWADDR) == cnt_irq_pkg::OFS_PENDING;
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("Flag cleared without write.");
    property p_nand;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        (I_SRC_ISO[0] && I_SRC_TTL[0]) |-> !O_CNT_SRC[0];
    endproperty
    a_nand: assert property (p_nand) else $error("Source combination wrong.");
    property p_filter;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        ovf_rise[3] |-> $past(I_CNT_OVF[3], 2) && $past(I_CNT_OVF[3], 3) && $past(I_CNT_OVF[3], 4);
    endproperty
    a_filter: assert property (p_filter) else $error("Spike passed filter.");
    c_grant: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) seq_r == SEQ_ACK ##1 seq_r == SEQ_DONE);
    c_rearm: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) $rose(master_r) && (|flag_r));
    c_irq: cover property (@(posedge I_CORE_CLK) disable iff (I_RST) $rose(O_IRQ));
endmodule

// >>> testbench/bus_grantor.sv
// Purpose: Behavioural bus processor that grants the interrupt request.
// Assumes: Grant is a level, held until the vector has been seen on the data lines.
// Notes:   The grant delay is set by the bench so the processor can act promptly or slowly.
`timescale 1ns/100ps
module bus_grantor (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Interrupt sequence
    input  wire logic        i_bus_irq,
    input  wire logic        i_vec_oe,
    input  wire logic [15:0] i_vec_data,
    input  wire logic [7:0]  i_delay,
    output logic             o_grant,
    output logic [15:0]      o_vec,
    output int               o_grants
);
    // One grant at a time; the request is checked again after the delay, since a withdrawn request gets no grant.
    initial begin
        int n;
        o_grant  = 1'b0;
        o_vec    = 16'h0000;
        o_grants = 0;
        forever begin
            @(posedge i_clk);
            if (!i_rst && i_bus_irq === 1'b1) begin
                repeat (i_delay) @(posedge i_clk);
                if (i_bus_irq === 1'b1) begin
                    o_grant <= 1'b1;
                    n = 0;
                    do begin
                        @(negedge i_clk);
                        n++;
                    end while (i_vec_oe !== 1'b1 && n < 50);
                    o_vec = i_vec_data;
                    @(posedge i_clk);
                    o_grant  <= 1'b0;
                    o_grants <= o_grants + 1;
                end
            end
        end
    end
endmodule

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the counter channel interrupt logic.
// Assumes: AXI4-Lite master changes signals by non-blocking assignment after a rising edge.
// Notes:   Random values come from a fixed seed so each run repeats exactly.
`timescale 1ns/100ps
module tb_top;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, grant, bus_irq, vec_oe, irq;
    logic [7:0]  awaddr, araddr, delay;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [4:0]  ovf, src_iso, src_ttl, gate_iso, gate_ttl, cnt_src, cnt_gate;
    logic [15:0] vec_sw, vec_data, vec_seen;
    int          grants, error_cnt, samples_checked, seed;

    counter_channel_irq_logic u_counter_channel_irq_logic (
        .I_CORE_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_CNT_OVF(ovf),
        .I_SRC_ISO(src_iso), .I_SRC_TTL(src_ttl), .I_GATE_ISO(gate_iso), .I_GATE_TTL(gate_ttl),
        .O_CNT_SRC(cnt_src), .O_CNT_GATE(cnt_gate), .I_IRQ_GRANT(grant), .I_VECTOR_SW(vec_sw),
        .O_BUS_IRQ(bus_irq), .O_VEC_DATA(vec_data), .O_VEC_OE(vec_oe), .O_IRQ(irq));

    bus_grantor u_bus_grantor (
        .i_clk(clk), .i_rst(rst), .i_bus_irq(bus_irq), .i_vec_oe(vec_oe), .i_vec_data(vec_data),
        .i_delay(delay), .o_grant(grant), .o_vec(vec_seen), .o_grants(grants));

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    // ************************************************************
    // Checking and bus tasks
    // ************************************************************
    function automatic logic [4:0] nand5(input logic [4:0] a, input logic [4:0] b);
        return ~(a & b);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask

    // Ready is looked at mid-cycle, so the transfer happens at the following rising edge.
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (s !== 1'b1 && n < 100);
        if (s !== 1'b1) error_cnt++;
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        wait_hi(awready);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        wait_hi(bvalid);
        chk_resp(bresp, er);
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        wait_hi(arready);
        @(posedge clk);
        arvalid <= 1'b0;
        wait_hi(rvalid);
        chk(rdata, e);
        chk_resp(rresp, er);
        @(posedge clk);
        rready <= 1'b0;
    endtask

    // The raw line is held for len edges, then left to settle through the filter.
    task automatic pulse(input int ch, input int len);
        @(posedge clk);
        ovf <= 5'h01 << ch;
        repeat (len) @(posedge clk);
        ovf <= 5'h00;
        repeat (12) @(posedge clk);
    endtask

    task automatic wait_grant(input int cnt);
        int n;
        n = 0;
        while (grants < cnt && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (grants < cnt) error_cnt++;
    endtask

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [4:0] en;
        logic [4:0] pend;
        {clk, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {ovf, src_iso, src_ttl, gate_iso, gate_ttl} = '0;
        {error_cnt, samples_checked, seed} = {32'd0, 32'd0, 32'd8};
        rst    = 1'b1;
        delay  = 8'h08;
        vec_sw = 16'($random(seed));
        en     = 5'($random(seed));
        en[0]  = 1'b1;
        en[1]  = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk(cnt_irq_pkg::OFS_ENABLE, 32'h0, cnt_irq_pkg::RESP_OKAY);
        rd_chk(cnt_irq_pkg::OFS_PENDING, 32'h0, cnt_irq_pkg::RESP_OKAY);
        rd_chk(cnt_irq_pkg::OFS_CONTROL, 32'h0, cnt_irq_pkg::RESP_OKAY);
        rd_chk(cnt_irq_pkg::OFS_IRQ_MASK, 32'h0, cnt_irq_pkg::RESP_OKAY);
        rd_chk(8'h14, 32'h0, cnt_irq_pkg::RESP_SLVERR);
        wr_chk(8'h14, 32'hFFFFFFFF, cnt_irq_pkg::RESP_SLVERR);
        // Counter inputs are plain combinational gates, so random patterns suit them.
        repeat (16) begin
            @(posedge clk);
            {src_iso, src_ttl, gate_iso, gate_ttl} <= 20'($random(seed));
            @(negedge clk);
            chk({27'h0, cnt_src}, {27'h0, nand5(src_iso, src_ttl)});
            chk({27'h0, cnt_gate}, {27'h0, nand5(gate_iso, gate_ttl)});
        end
        pulse(2, 8);
        rd_chk(cnt_irq_pkg::OFS_PENDING, 32'h0, cnt_irq_pkg::RESP_OKAY);
        wr_chk(cnt_irq_pkg::OFS_ENABLE, {27'h0, en}, cnt_irq_pkg::RESP_OKAY);
        pend = 5'h00;
        for (int i = 0; i < cnt_irq_pkg::NUM_CH; i++) begin
            pulse(i, 1);
            rd_chk(cnt_irq_pkg::OFS_PENDING, {27'h0, pend}, cnt_irq_pkg::RESP_OKAY);
            pulse(i, 8);
            pend[i] = en[i];
            rd_chk(cnt_irq_pkg::OFS_PENDING, {27'h0, pend}, cnt_irq_pkg::RESP_OKAY);
        end
        @(negedge clk);
        chk(32'(bus_irq), 32'h0);
        // Local interrupt: raise through the mask, then clear the sticky status.
        wr_chk(cnt_irq_pkg::OFS_IRQ_MASK, 32'h2, cnt_irq_pkg::RESP_OKAY);
        @(negedge clk);
        chk(32'(irq), 32'h1);
        wr_chk(cnt_irq_pkg::OFS_IRQ_STAT, 32'h3, cnt_irq_pkg::RESP_OKAY);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        // Software scans the pending flags before enabling the bus request.
        rd_chk(cnt_irq_pkg::OFS_PENDING, {27'h0, pend}, cnt_irq_pkg::RESP_OKAY);
        wr_chk(cnt_irq_pkg::OFS_CONTROL, 32'h1, cnt_irq_pkg::RESP_OKAY);
        @(negedge clk);
        chk(32'(bus_irq), 32'h1);
        wait_grant(1);
        chk({16'h0, vec_seen}, {16'h0, vec_sw});
        repeat (6) @(negedge clk);
        chk(32'(bus_irq), 32'h0);
        chk(32'(vec_oe), 32'h0);
        rd_chk(cnt_irq_pkg::OFS_CONTROL, 32'h0, cnt_irq_pkg::RESP_OKAY);
        rd_chk(cnt_irq_pkg::OFS_PENDING, {27'h0, pend}, cnt_irq_pkg::RESP_OKAY);
        rd_chk(cnt_irq_pkg::OFS_IRQ_STAT, 32'h1, cnt_irq_pkg::RESP_OKAY);
        wr_chk(cnt_irq_pkg::OFS_PENDING, 32'h1F, cnt_irq_pkg::RESP_OKAY);
        rd_chk(cnt_irq_pkg::OFS_PENDING, 32'h0, cnt_irq_pkg::RESP_OKAY);
        // Slow processor: enable with nothing pending, then let one channel fire.
        delay  <= 8'h1E;
        vec_sw <= 16'($random(seed));
        wr_chk(cnt_irq_pkg::OFS_CONTROL, 32'h1, cnt_irq_pkg::RESP_OKAY);
        repeat (10) @(negedge clk);
        chk(32'(bus_irq), 32'h0);
        pulse(0, 8);
        @(negedge clk);
        chk(32'(bus_irq), 32'h1);
        wait_grant(2);
        chk({16'h0, vec_seen}, {16'h0, vec_sw});
        rd_chk(cnt_irq_pkg::OFS_CONTROL, 32'h0, cnt_irq_pkg::RESP_OKAY);
        wrap_up();
    end

    // Watchdog sized well beyond the few hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
endmodule
